/* design/cfgacc_pkg.sv */
package cfgacc_pkg;
  // control tokens carried on the link
  localparam logic [7:0] TOK_CFG_WR = 8'hC0;
  localparam logic [7:0] TOK_CFG_RD = 8'hC1;
  localparam logic [7:0] TOK_PER_RD = 8'h25;
  localparam logic [7:0] TOK_END = 8'h01;
  localparam logic [7:0] TOK_ACK = 8'h03;
  localparam logic [7:0] TOK_NAK = 8'h04;
  // destination word low parts
  localparam logic [15:0] TILE_DEST_LO = 16'hC20C;
  localparam logic [15:0] NODE_DEST_LO = 16'hC30C;
  localparam logic [7:0] PERIPH_DEST_LO = 8'h02;
  // processor-status resource identifier
  localparam logic [7:0] PS_RES_TYPE = 8'h0C;
  localparam int PS_SHIFT = 8;
  // message field lengths in bytes
  localparam logic [3:0] ID_BYTES = 4'h3;
  localparam logic [3:0] WR_FIELD_BYTES = 4'h6;
  localparam logic [3:0] RD_FIELD_BYTES = 4'h2;
  localparam logic [3:0] PER_MAX_SIZE = 4'h4;
  localparam logic [3:0] WR_MSG_LEN = 4'hB;
  localparam logic [3:0] RD_MSG_LEN = 4'h7;
  // register storage
  localparam int ID_W = 16;
  localparam int CFG_REGS = 8;
  localparam int CFG_IDX_W = 3;
  localparam int PER_REGS = 16;
  localparam int PER_IDX_W = 4;
  localparam int PS_REGS = 8;
  localparam int PS_IDX_W = 3;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [7:0] PER_RESET = 8'h00;

  typedef enum logic [2:0] {
    OP_CFG_WR = 3'h0,
    OP_CFG_RD = 3'h1,
    OP_PER_RD = 3'h2,
    OP_PS_RD = 3'h3,
    OP_PS_WR = 3'h4
  } cfgacc_op_t;
endpackage : cfgacc_pkg

/* design/cfgacc_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface cfgacc_if;
  logic [31:0] req_dest;
  logic req_valid;
  logic req_ctrl;
  logic [7:0] req_data;
  logic req_ready;
  logic rsp_valid;
  logic rsp_ctrl;
  logic [7:0] rsp_data;
  logic [23:0] rsp_dest;
  logic rsp_ready;
  logic ps_valid;
  logic ps_write;
  logic [31:0] ps_resid;
  logic [31:0] ps_wdata;
  logic ps_ack;
  logic ps_err;
  logic [31:0] ps_rdata;

  modport responder (
    input req_dest, req_valid, req_ctrl, req_data, rsp_ready,
    input ps_valid, ps_write, ps_resid, ps_wdata,
    output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest,
    output ps_ack, ps_err, ps_rdata
  );
  modport requester (
    output req_dest, req_valid, req_ctrl, req_data, rsp_ready,
    output ps_valid, ps_write, ps_resid, ps_wdata,
    input req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest,
    input ps_ack, ps_err, ps_rdata
  );
endinterface : cfgacc_if
`default_nettype wire

/* design/cfgacc_requester.sv */
`timescale 1ns/10ps
`default_nettype none
module cfgacc_requester (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire cfgacc_pkg::cfgacc_op_t cmd_op,
  input wire logic [31:0] cmd_dest,
  input wire logic [23:0] cmd_reply_id,
  input wire logic [15:0] cmd_reg,
  input wire logic [7:0] cmd_size,
  input wire logic [31:0] cmd_wdata,
  output logic cmd_ready,
  output logic done,
  output logic ok,
  output logic [31:0] rdata,
  cfgacc_if.requester link
);
  import cfgacc_pkg::*;

  typedef enum logic [1:0] {
    RQ_IDLE = 2'b00,
    RQ_SEND = 2'b01,
    RQ_WAIT = 2'b11,
    RQ_PS = 2'b10
  } cfgacc_rq_state_t;

  cfgacc_rq_state_t state_reg, state_next;
  logic [79:0] msg_reg, msg_next;
  logic [3:0] pos_reg, pos_next;
  logic [3:0] len_reg, len_next;
  logic [31:0] dest_reg, dest_next;
  logic req_valid_reg, req_valid_next;
  logic req_ctrl_reg, req_ctrl_next;
  logic [7:0] req_data_reg, req_data_next;
  logic rsp_ready_reg, rsp_ready_next;
  logic ps_valid_reg, ps_valid_next;
  logic ps_write_reg, ps_write_next;
  logic [31:0] ps_resid_reg, ps_resid_next;
  logic [31:0] ps_wdata_reg, ps_wdata_next;
  logic cmd_ready_reg, cmd_ready_next;
  logic done_reg, done_next;
  logic ok_reg, ok_next;
  logic [31:0] rdata_reg, rdata_next;

  always_comb begin
    state_next = state_reg;
    msg_next = msg_reg;
    pos_next = pos_reg;
    len_next = len_reg;
    dest_next = dest_reg;
    req_valid_next = req_valid_reg;
    req_ctrl_next = req_ctrl_reg;
    req_data_next = req_data_reg;
    rsp_ready_next = rsp_ready_reg;
    ps_valid_next = ps_valid_reg;
    ps_write_next = ps_write_reg;
    ps_resid_next = ps_resid_reg;
    ps_wdata_next = ps_wdata_reg;
    done_next = 1'b0;
    ok_next = ok_reg;
    rdata_next = rdata_reg;
    unique case (state_reg)
      RQ_IDLE: begin
        if (cmd_valid && cmd_ready_reg) begin
          rdata_next = REG_RESET;
          if (cmd_op == OP_PS_RD || cmd_op == OP_PS_WR) begin
            ps_valid_next = 1'b1;
            ps_write_next = (cmd_op == OP_PS_WR);
            ps_resid_next = ({16'h0000, cmd_reg} << PS_SHIFT)
                            | {24'h000000, PS_RES_TYPE};
            ps_wdata_next = cmd_wdata;
            state_next = RQ_PS;
          end else begin
            dest_next = cmd_dest;
            req_valid_next = 1'b1;
            req_ctrl_next = 1'b1;
            pos_next = 4'h0;
            len_next = RD_MSG_LEN;
            if (cmd_op == OP_CFG_WR) begin
              req_data_next = TOK_CFG_WR;
              msg_next = {cmd_reply_id, cmd_reg, cmd_wdata, TOK_END};
              len_next = WR_MSG_LEN;
            end else if (cmd_op == OP_CFG_RD) begin
              req_data_next = TOK_CFG_RD;
              msg_next = {cmd_reply_id, cmd_reg, TOK_END, 32'h0};
            end else begin
              req_data_next = TOK_PER_RD;
              msg_next = {cmd_reply_id, cmd_reg[7:0], cmd_size, TOK_END,
                          32'h0};
            end
            state_next = RQ_SEND;
          end
        end
      end
      RQ_SEND: begin
        if (link.req_ready && req_valid_reg) begin
          pos_next = pos_reg + 4'h1;
          if (pos_reg + 4'h1 == len_reg) begin
            req_valid_next = 1'b0;
            rsp_ready_next = 1'b1;
            state_next = RQ_WAIT;
          end else begin
            req_data_next = msg_reg[79:72];
            req_ctrl_next = (pos_reg + 4'h2 == len_reg);
            msg_next = {msg_reg[71:0], 8'h00};
          end
        end
      end
      RQ_WAIT: begin
        if (link.rsp_valid && rsp_ready_reg) begin
          if (!link.rsp_ctrl) begin
            rdata_next = {rdata_reg[23:0], link.rsp_data};
          end else if (link.rsp_data == TOK_END) begin
            done_next = 1'b1;
            rsp_ready_next = 1'b0;
            state_next = RQ_IDLE;
          end else begin
            ok_next = (link.rsp_data == TOK_ACK);
          end
        end
      end
      RQ_PS: begin
        if (link.ps_ack) begin
          ps_valid_next = 1'b0;
          done_next = 1'b1;
          ok_next = !link.ps_err;
          if (!ps_write_reg) begin
            rdata_next = link.ps_rdata;
          end
          state_next = RQ_IDLE;
        end
      end
    endcase
    cmd_ready_next = (state_next == RQ_IDLE);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= RQ_IDLE;
      msg_reg <= '0;
      pos_reg <= 4'h0;
      len_reg <= 4'h0;
      dest_reg <= REG_RESET;
      req_valid_reg <= 1'b0;
      req_ctrl_reg <= 1'b0;
      req_data_reg <= 8'h00;
      rsp_ready_reg <= 1'b0;
      ps_valid_reg <= 1'b0;
      ps_write_reg <= 1'b0;
      ps_resid_reg <= REG_RESET;
      ps_wdata_reg <= REG_RESET;
      cmd_ready_reg <= 1'b0;
      done_reg <= 1'b0;
      ok_reg <= 1'b0;
      rdata_reg <= REG_RESET;
    end else begin
      state_reg <= state_next;
      msg_reg <= msg_next;
      pos_reg <= pos_next;
      len_reg <= len_next;
      dest_reg <= dest_next;
      req_valid_reg <= req_valid_next;
      req_ctrl_reg <= req_ctrl_next;
      req_data_reg <= req_data_next;
      rsp_ready_reg <= rsp_ready_next;
      ps_valid_reg <= ps_valid_next;
      ps_write_reg <= ps_write_next;
      ps_resid_reg <= ps_resid_next;
      ps_wdata_reg <= ps_wdata_next;
      cmd_ready_reg <= cmd_ready_next;
      done_reg <= done_next;
      ok_reg <= ok_next;
      rdata_reg <= rdata_next;
    end
  end

  assign link.req_dest = dest_reg;
  assign link.req_valid = req_valid_reg;
  assign link.req_ctrl = req_ctrl_reg;
  assign link.req_data = req_data_reg;
  assign link.rsp_ready = rsp_ready_reg;
  assign link.ps_valid = ps_valid_reg;
  assign link.ps_write = ps_write_reg;
  assign link.ps_resid = ps_resid_reg;
  assign link.ps_wdata = ps_wdata_reg;
  assign cmd_ready = cmd_ready_reg;
  assign done = done_reg;
  assign ok = ok_reg;
  assign rdata = rdata_reg;
endmodule : cfgacc_requester
`default_nettype wire

/* design/cfgacc_responder.sv */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - status id is register shifted 8, or 0x0C
// - status read or write moves one word
// - tile space: tile id, low half C20C
// - node space: node id, low half C30C
// - peripheral space: node, peripheral, low byte 02
// - write: 192, reply id, register, data, 1
// - write answer: 3,1 success; 4,1 failure
// - read: 193, reply id, register, 1
// - read answer: 3, word, 1; or 4,1
// - peripheral read: 37, id, register, size, 1
module cfgacc_responder (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [cfgacc_pkg::ID_W-1:0] tile_id,
  input wire logic [cfgacc_pkg::ID_W-1:0] node_id,
  input wire logic [7:0] periph_id,
  output logic busy,
  cfgacc_if.responder link
);
  import cfgacc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HEAD = 3'b001,
    ST_TAIL = 3'b011,
    ST_EXEC = 3'b010,
    ST_REPLY = 3'b110,
    ST_DRAIN = 3'b100
  } cfgacc_state_t;

  cfgacc_state_t state_reg, state_next;
  logic [7:0] op_reg, op_next;
  logic [31:0] dest_reg, dest_next;
  logic [23:0] id_reg, id_next;
  logic [47:0] fld_reg, fld_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [3:0] need_reg, need_next;
  logic bad_reg, bad_next;
  logic [31:0] tile_reg [CFG_REGS];
  logic [31:0] tile_next [CFG_REGS];
  logic [31:0] node_reg [CFG_REGS];
  logic [31:0] node_next [CFG_REGS];
  logic [7:0] per_reg [PER_REGS];
  logic [31:0] out_reg, out_next;
  logic [2:0] rpos_reg, rpos_next;
  logic [2:0] rlen_reg, rlen_next;
  logic req_ready_reg, req_ready_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic rsp_ctrl_reg, rsp_ctrl_next;
  logic [7:0] rsp_data_reg, rsp_data_next;
  logic [23:0] rsp_dest_reg, rsp_dest_next;
  logic busy_reg, busy_next;
  logic take;
  logic is_tile, is_node, is_per, cfg_op, cfg_ok, per_ok, ok;
  logic [15:0] cfg_num;
  logic [CFG_IDX_W-1:0] cfg_idx;
  logic [PER_IDX_W-1:0] per_idx;
  logic [7:0] per_size;
  logic [8:0] per_end;
  logic [31:0] rd_word;

  // status register group
  logic [31:0] ps_reg [PS_REGS];
  logic [31:0] ps_next [PS_REGS];
  logic ps_ack_reg, ps_ack_next;
  logic ps_err_reg, ps_err_next;
  logic [31:0] ps_rdata_reg, ps_rdata_next;
  logic ps_hit;
  logic [PS_IDX_W-1:0] ps_idx;

  // peripheral bytes are read-only here: their write message is not defined
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      per_reg <= '{default: PER_RESET};
    end
  end

  always_comb begin
    is_tile = (dest_reg == {tile_id, TILE_DEST_LO});
    is_node = (dest_reg == {node_id, NODE_DEST_LO});
    is_per = (dest_reg == {node_id, periph_id, PERIPH_DEST_LO});
    cfg_op = (op_reg == TOK_CFG_WR) || (op_reg == TOK_CFG_RD);
    cfg_num = (op_reg == TOK_CFG_WR) ? fld_reg[47:32] : fld_reg[15:0];
    cfg_idx = cfg_num[CFG_IDX_W-1:0];
    cfg_ok = (is_tile || is_node) && cfg_op && (cfg_num < 16'(CFG_REGS));
    per_idx = fld_reg[8+PER_IDX_W-1:8];
    per_size = fld_reg[7:0];
    per_end = {1'b0, fld_reg[15:8]} + {1'b0, per_size};
    per_ok = is_per && (op_reg == TOK_PER_RD) && (per_size != 8'h00)
             && (per_size <= {4'h0, PER_MAX_SIZE})
             && (per_end <= 9'(PER_REGS));
    ok = !bad_reg && (cfg_ok || per_ok);
    rd_word = is_tile ? tile_reg[cfg_idx] : node_reg[cfg_idx];
    if (is_per) begin
      rd_word = 32'h0000_0000;
      for (int k = 0; k < 4; k++) begin
        if (k < int'(per_size)) begin
          rd_word[31-8*k -: 8] = per_reg[per_idx + PER_IDX_W'(k)];
        end
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    dest_next = dest_reg;
    id_next = id_reg;
    fld_next = fld_reg;
    cnt_next = cnt_reg;
    need_next = need_reg;
    bad_next = bad_reg;
    tile_next = tile_reg;
    node_next = node_reg;
    out_next = out_reg;
    rpos_next = rpos_reg;
    rlen_next = rlen_reg;
    rsp_valid_next = rsp_valid_reg;
    rsp_ctrl_next = rsp_ctrl_reg;
    rsp_data_next = rsp_data_reg;
    rsp_dest_next = rsp_dest_reg;
    take = link.req_valid && req_ready_reg;
    unique case (state_reg)
      ST_IDLE: begin
        // stray data outside a message is dropped
        if (take && link.req_ctrl) begin
          op_next = link.req_data;
          dest_next = link.req_dest;
          cnt_next = 4'h0;
          bad_next = 1'b0;
          id_next = 24'h000000;
          if (link.req_data == TOK_CFG_WR) begin
            need_next = ID_BYTES + WR_FIELD_BYTES;
          end else if (link.req_data == TOK_CFG_RD
                       || link.req_data == TOK_PER_RD) begin
            need_next = ID_BYTES + RD_FIELD_BYTES;
          end else begin
            // unknown leading token: keep the reply id, then fail
            need_next = ID_BYTES;
            bad_next = 1'b1;
          end
          state_next = ST_HEAD;
        end
      end
      ST_HEAD: begin
        if (take) begin
          if (link.req_ctrl) begin
            bad_next = 1'b1;
            state_next = ST_EXEC;
          end else begin
            if (cnt_reg < ID_BYTES) begin
              id_next = {id_reg[15:0], link.req_data};
            end else begin
              fld_next = {fld_reg[39:0], link.req_data};
            end
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg + 4'h1 == need_reg) begin
              state_next = bad_reg ? ST_DRAIN : ST_TAIL;
            end
          end
        end
      end
      ST_TAIL: begin
        if (take) begin
          if (!link.req_ctrl) begin
            bad_next = 1'b1;
            state_next = ST_DRAIN;
          end else begin
            bad_next = (link.req_data != TOK_END);
            state_next = ST_EXEC;
          end
        end
      end
      ST_DRAIN: begin
        if (take && link.req_ctrl) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (ok && op_reg == TOK_CFG_WR) begin
          if (is_tile) begin
            tile_next[cfg_idx] = fld_reg[31:0];
          end else begin
            node_next[cfg_idx] = fld_reg[31:0];
          end
        end
        rsp_valid_next = 1'b1;
        rsp_ctrl_next = 1'b1;
        rsp_data_next = ok ? TOK_ACK : TOK_NAK;
        rsp_dest_next = id_reg;
        out_next = rd_word;
        rpos_next = 3'h0;
        rlen_next = 3'h2;
        if (ok && op_reg == TOK_CFG_RD) begin
          rlen_next = 3'h6;
        end else if (ok && op_reg == TOK_PER_RD) begin
          rlen_next = 3'h2 + per_size[2:0];
        end
        state_next = ST_REPLY;
      end
      ST_REPLY: begin
        if (link.rsp_ready && rsp_valid_reg) begin
          rpos_next = rpos_reg + 3'h1;
          if (rpos_reg + 3'h1 == rlen_reg) begin
            rsp_valid_next = 1'b0;
            state_next = ST_IDLE;
          end else if (rpos_reg + 3'h2 == rlen_reg) begin
            rsp_ctrl_next = 1'b1;
            rsp_data_next = TOK_END;
          end else begin
            rsp_ctrl_next = 1'b0;
            rsp_data_next = out_reg[31:24];
            out_next = {out_reg[23:0], 8'h00};
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    req_ready_next = (state_next == ST_IDLE) || (state_next == ST_HEAD)
                     || (state_next == ST_TAIL) || (state_next == ST_DRAIN);
    busy_next = (state_next != ST_IDLE);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      op_reg <= 8'h00;
      dest_reg <= REG_RESET;
      id_reg <= 24'h000000;
      fld_reg <= '0;
      cnt_reg <= 4'h0;
      need_reg <= 4'h0;
      bad_reg <= 1'b0;
      tile_reg <= '{default: REG_RESET};
      node_reg <= '{default: REG_RESET};
      out_reg <= REG_RESET;
      rpos_reg <= 3'h0;
      rlen_reg <= 3'h0;
      req_ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_ctrl_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
      rsp_dest_reg <= 24'h000000;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      dest_reg <= dest_next;
      id_reg <= id_next;
      fld_reg <= fld_next;
      cnt_reg <= cnt_next;
      need_reg <= need_next;
      bad_reg <= bad_next;
      tile_reg <= tile_next;
      node_reg <= node_next;
      out_reg <= out_next;
      rpos_reg <= rpos_next;
      rlen_reg <= rlen_next;
      req_ready_reg <= req_ready_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_ctrl_reg <= rsp_ctrl_next;
      rsp_data_reg <= rsp_data_next;
      rsp_dest_reg <= rsp_dest_next;
      busy_reg <= busy_next;
    end
  end

  always_comb begin
    ps_next = ps_reg;
    ps_ack_next = 1'b0;
    ps_err_next = ps_err_reg;
    ps_rdata_next = ps_rdata_reg;
    ps_idx = link.ps_resid[PS_SHIFT+PS_IDX_W-1:PS_SHIFT];
    ps_hit = (link.ps_resid[7:0] == PS_RES_TYPE)
             && (link.ps_resid[31:16] == 16'h0000)
             && (link.ps_resid[15:8] < 8'(PS_REGS));
    // ps_valid still high in the cycle that ps_ack is high makes no second access
    if (link.ps_valid && !ps_ack_reg) begin
      ps_ack_next = 1'b1;
      ps_err_next = !ps_hit;
      if (ps_hit && link.ps_write) begin
        ps_next[ps_idx] = link.ps_wdata;
      end else if (ps_hit) begin
        ps_rdata_next = ps_reg[ps_idx];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ps_reg <= '{default: REG_RESET};
      ps_ack_reg <= 1'b0;
      ps_err_reg <= 1'b0;
      ps_rdata_reg <= REG_RESET;
    end else begin
      ps_reg <= ps_next;
      ps_ack_reg <= ps_ack_next;
      ps_err_reg <= ps_err_next;
      ps_rdata_reg <= ps_rdata_next;
    end
  end

  assign link.req_ready = req_ready_reg;
  assign link.rsp_valid = rsp_valid_reg;
  assign link.rsp_ctrl = rsp_ctrl_reg;
  assign link.rsp_data = rsp_data_reg;
  assign link.rsp_dest = rsp_dest_reg;
  assign link.ps_ack = ps_ack_reg;
  assign link.ps_err = ps_err_reg;
  assign link.ps_rdata = ps_rdata_reg;
  assign busy = busy_reg;
endmodule : cfgacc_responder
`default_nettype wire

/* verif/cfgacc_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module cfgacc_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_ctrl,
  input wire logic [7:0] rsp_data,
  input wire logic [23:0] rsp_dest,
  input wire logic rsp_ready,
  input wire logic ps_valid,
  input wire logic [31:0] ps_resid,
  input wire logic ps_ack,
  input wire logic ps_err
);
  import cfgacc_pkg::*;
  logic take;
  logic ps_bad;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  assign take = rsp_valid && rsp_ready;
  assign ps_bad = ps_resid[7:0] != PS_RES_TYPE || ps_resid[31:16] != 16'h0
    || ps_resid[15:8] >= 8'(PS_REGS);
  // data symbols since the last control symbol of a reply
  always_comb begin
    cnt_next = cnt_reg;
    if (take) cnt_next = rsp_ctrl ? 4'h0 : cnt_reg + 4'h1;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) cnt_reg <= 4'h0;
    else cnt_reg <= cnt_next;
  end
  status_answer_a: assert property (ps_valid && !ps_ack |=>
    ps_ack && ps_err == $past(ps_bad)) else $error("status answer wrong");
  ack_pulse_a: assert property (ps_ack |=> !ps_ack)
    else $error("status ack too long");
  reply_start_a: assert property ($fell(req_ready) |=> rsp_valid &&
    rsp_ctrl && (rsp_data == TOK_ACK || rsp_data == TOK_NAK))
    else $error("reply does not open with a status token");
  refuse_reply_a: assert property (rsp_valid |-> !req_ready)
    else $error("request taken during reply");
  nak_end_a: assert property (take && rsp_ctrl && rsp_data == TOK_NAK
    |=> rsp_valid && rsp_ctrl && rsp_data == TOK_END)
    else $error("failure not closed by end token");
  reply_once_a: assert property (take && rsp_ctrl &&
    rsp_data == TOK_END |=> !rsp_valid [*3])
    else $error("reply continues after end token");
  dest_steady_a: assert property (rsp_valid && $past(rsp_valid)
    |-> $stable(rsp_dest)) else $error("reply destination moved");
  data_count_a: assert property (take && rsp_ctrl &&
    rsp_data == TOK_END |-> cnt_reg <= 4'h4)
    else $error("reply carries too many data bytes");
  cover property (take && rsp_ctrl && rsp_data == TOK_ACK);
  cover property (take && rsp_ctrl && rsp_data == TOK_NAK);
  cover property (ps_ack && !ps_err);
  cover property (ps_ack && ps_err);
endmodule : cfgacc_monitor
`default_nettype wire

/* verif/cfgacc_test.sv */
`timescale 1ns/10ps
`default_nettype none
module cfgacc_test;
  import cfgacc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  cfgacc_op_t cmd_op = OP_CFG_WR;
  logic [31:0] cmd_dest = 32'h0;
  logic [23:0] cmd_reply_id = 24'h0;
  logic [15:0] cmd_reg = 16'h0;
  logic [7:0] cmd_size = 8'h0;
  logic [31:0] cmd_wdata = 32'h0;
  logic [15:0] tid = 16'h0005;
  logic [15:0] nid = 16'h00A3;
  logic [7:0] pid = 8'h06;
  logic [23:0] id = 24'h12345F;
  logic cmd_ready, done, ok, busy, busy2;
  logic [31:0] rdata, qdst, pdst, dt, dn, dp;
  logic [23:0] rdst, rdst2;
  logic [8:0] sq[$], rq[$], q2[$];
  logic [8:0] nakq[$] = '{9'h104, 9'h101};
  int n_errors = 0;
  int n_tests = 0;
  cfgacc_if lk();
  cfgacc_if lk2();
  assign dt = {tid, TILE_DEST_LO};
  assign dn = {nid, NODE_DEST_LO};
  assign dp = {nid, pid, PERIPH_DEST_LO};
  cfgacc_requester cfgacc_requester_i (.clk(clk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_dest(cmd_dest),
    .cmd_reply_id(cmd_reply_id), .cmd_reg(cmd_reg), .cmd_size(cmd_size),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .done(done), .ok(ok),
    .rdata(rdata), .link(lk.requester));
  cfgacc_responder cfgacc_responder_i (.clk(clk), .resetn(resetn),
    .tile_id(tid), .node_id(nid), .periph_id(pid), .busy(busy),
    .link(lk.responder));
  // second responder faces the bench so broken messages can be sent
  cfgacc_responder cfgacc_responder_i2 (.clk(clk), .resetn(resetn),
    .tile_id(tid), .node_id(nid), .periph_id(pid), .busy(busy2),
    .link(lk2.responder));
  cfgacc_monitor cfgacc_monitor_i (.clk(clk), .resetn(resetn),
    .req_ready(lk.req_ready), .rsp_valid(lk.rsp_valid),
    .rsp_ctrl(lk.rsp_ctrl), .rsp_data(lk.rsp_data),
    .rsp_dest(lk.rsp_dest), .rsp_ready(lk.rsp_ready),
    .ps_valid(lk.ps_valid), .ps_resid(lk.ps_resid),
    .ps_ack(lk.ps_ack), .ps_err(lk.ps_err));
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (lk.req_valid && lk.req_ready && sq.size() == 0) qdst = lk.req_dest;
    if (lk.req_valid && lk.req_ready) sq.push_back({lk.req_ctrl, lk.req_data});
    if (lk.rsp_valid && lk.rsp_ready) rq.push_back({lk.rsp_ctrl, lk.rsp_data});
    if (lk.rsp_valid) rdst = lk.rsp_dest;
    if (lk.ps_valid) pdst = lk.ps_resid;
    if (lk2.rsp_valid) q2.push_back({lk2.rsp_ctrl, lk2.rsp_data});
    if (lk2.rsp_valid) rdst2 = lk2.rsp_dest;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cq(input logic [8:0] a[$], input logic [8:0] b[$]);
    chk(32'(a.size()), 32'(b.size()));
    foreach (b[i]) chk(32'(a[i]), 32'(b[i]));
  endtask : cq
  // entered and left just after a rising edge
  task automatic wt(ref logic s);
    for (int k = 0; k < 80 && s !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
  endtask : wt
  // d is the write word, or the word a read should return
  task automatic run(input cfgacc_op_t op, input logic [31:0] dst,
      input logic [15:0] rg, input logic [7:0] sz, input logic [31:0] d,
      input logic okx);
    logic [8:0] eq[$];
    logic [8:0] er[$];
    int n;
    id = id + 24'h010203;
    n = op == OP_CFG_RD ? 4 : op == OP_PER_RD ? int'(sz) : 0;
    eq.push_back({1'b1, op == OP_CFG_WR ? TOK_CFG_WR
      : op == OP_CFG_RD ? TOK_CFG_RD : TOK_PER_RD});
    for (int i = 2; i >= 0; i--) eq.push_back({1'b0, id[8*i +: 8]});
    eq.push_back({1'b0, op == OP_PER_RD ? rg[7:0] : rg[15:8]});
    eq.push_back({1'b0, op == OP_PER_RD ? sz : rg[7:0]});
    for (int i = 3; i >= 0; i--)
      if (op == OP_CFG_WR) eq.push_back({1'b0, d[8*i +: 8]});
    eq.push_back(9'h101);
    er.push_back({1'b1, okx ? TOK_ACK : TOK_NAK});
    for (int i = n - 1; i >= 0; i--)
      if (okx) er.push_back({1'b0, d[8*i +: 8]});
    er.push_back(9'h101);
    sq.delete();
    rq.delete();
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_dest = dst;
    cmd_reply_id = id;
    cmd_reg = rg;
    cmd_size = sz;
    cmd_wdata = d;
    wt(cmd_ready);
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    wt(done);
    chk(32'(done), 32'h1);
    chk(32'(ok), 32'(okx));
    chk(32'(busy), 32'h0);
    if (okx && (op == OP_CFG_RD || op == OP_PS_RD)) chk(rdata, d);
    if (op >= OP_PS_RD) chk(pdst, 32'(rg[7:0]) << 8 | 32'(PS_RES_TYPE));
    else begin
      cq(sq, eq);
      cq(rq, er);
      chk(32'(rdst), 32'(id));
      chk(qdst, dst);
    end
  endtask : run
  task automatic s2(input logic [8:0] v);
    lk2.req_valid = 1'b1;
    {lk2.req_ctrl, lk2.req_data} = v;
    for (int k = 0; k < 80 && lk2.req_ready !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
  endtask : s2
  task automatic f2(input logic [7:0] lead, input int nb);
    q2.delete();
    s2({1'b1, lead});
    chk(32'(busy2), 32'h1);
    for (int i = 0; i < nb; i++) s2({1'b0, 8'h0A + 8'(i)});
    s2(9'h101);
    lk2.req_valid = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    cq(q2, nakq);
    chk(32'(busy2), 32'h0);
    chk(32'(rdst2), 32'h000A0B0C);
  endtask : f2
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #(25 * 4000);
    n_errors++;
    final_report();
  end
  initial begin
    {lk2.req_valid, lk2.req_ctrl, lk2.req_data} = 10'h0;
    lk2.req_dest = 32'h0;
    lk2.rsp_ready = 1'b1;
    {lk2.ps_valid, lk2.ps_write} = 2'h0;
    {lk2.ps_resid, lk2.ps_wdata} = 64'h0;
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'b1;
    lk2.req_dest = dt;
    repeat (2) @(posedge clk);
    #1;
    run(OP_CFG_RD, dt, 16'h0003, 8'h0, 32'h0, 1'b1);
    run(OP_CFG_WR, dt, 16'h0007, 8'h0, 32'hDEADBEEF, 1'b1);
    run(OP_CFG_RD, dt, 16'h0007, 8'h0, 32'hDEADBEEF, 1'b1);
    run(OP_CFG_WR, dt, 16'h0008, 8'h0, 32'h1, 1'b0);
    run(OP_CFG_WR, dt ^ 32'h10000, 16'h0007, 8'h0, 32'h2, 1'b0);
    run(OP_CFG_WR, dt ^ 32'h1, 16'h0007, 8'h0, 32'h3, 1'b0);
    run(OP_CFG_RD, dt, 16'h0007, 8'h0, 32'hDEADBEEF, 1'b1);
    $display("test tile done");
    run(OP_CFG_WR, dn, 16'h0000, 8'h0, 32'h01234567, 1'b1);
    run(OP_CFG_RD, dn, 16'h0000, 8'h0, 32'h01234567, 1'b1);
    run(OP_CFG_RD, dt, 16'h0000, 8'h0, 32'h0, 1'b1);
    run(OP_CFG_RD, dn ^ 32'h10000, 16'h0000, 8'h0, 32'h0, 1'b0);
    $display("test node done");
    run(OP_PER_RD, dp, 16'h000C, 8'h04, 32'h0, 1'b1);
    run(OP_PER_RD, dp, 16'h0000, 8'h01, 32'h0, 1'b1);
    run(OP_PER_RD, dp, 16'h000D, 8'h04, 32'h0, 1'b0);
    run(OP_PER_RD, dp, 16'h0000, 8'h00, 32'h0, 1'b0);
    run(OP_PER_RD, dp, 16'h0000, 8'h05, 32'h0, 1'b0);
    run(OP_PER_RD, dt, 16'h0000, 8'h01, 32'h0, 1'b0);
    run(OP_CFG_RD, dp, 16'h0000, 8'h00, 32'h0, 1'b0);
    run(OP_PER_RD, dp ^ 32'h100, 16'h0000, 8'h01, 32'h0, 1'b0);
    $display("test peripheral done");
    run(OP_PS_WR, 32'h0, 16'h0002, 8'h0, 32'hA5A55A5A, 1'b1);
    run(OP_PS_RD, 32'h0, 16'h0002, 8'h0, 32'hA5A55A5A, 1'b1);
    run(OP_PS_RD, 32'h0, 16'h0007, 8'h0, 32'h0, 1'b1);
    run(OP_PS_WR, 32'h0, 16'h0008, 8'h0, 32'h1, 1'b0);
    $display("test status done");
    f2(8'h55, 4);
    f2(TOK_CFG_RD, 4);
    f2(TOK_CFG_RD, 6);
    f2(TOK_CFG_WR, 7);
    $display("test fault done");
    final_report();
  end
endmodule : cfgacc_test
`default_nettype wire
